// ---- hw/sfc_flash_seq.sv ----
// Overview of operation
// R1 - Block erase sets every bit of the addressed 64K block to one.
// R2 - Opcode D8 decodes as the 64K block erase.
// R3 - Host sets the write enable latch before erase or program.
// R4 - Erase discarded unless chip select rises on a byte boundary.
// R5 - Self-timed cycle sets write-in-progress, then clears it and the latch.
// R6 - Protected block or page is left unchanged.
// R7 - Chip erase is opcode only, ending on the byte boundary.
// R8 - Chip erase runs only when no region is protected.
// R9 - Page program needs whole data bytes; otherwise rejected.
// R10 - Program address wraps to start of the same page.
// R11 - Only the last 256 data bytes are kept.
// R12 - Host should program whole aligned pages once each.
// R13 - Opcode B9 enters deep power-down.
// R14 - Power-down begins after the entry delay.
// R15 - In power-down only opcode AB is accepted.
// R16 - Wake acts only on byte boundary; exit takes the exit delay.
// R17 - Signature byte repeats while clocked; immediate when not powered down.
// R18 - Wake and signature read ignored during a write cycle.
// R19 - Opcode 90 plus three dummies returns maker then device ID, alternating.
// R20 - Opcode 9F returns 24 ID bits, not decoded while busy.
// R21 - No-operation only cancels a pending reset arm.
// R22 - Reset acts only directly after reset arm; restores power-on state.
// R23 - Reset during program or erase aborts it.
// R24 - Inputs sampled on rising clock edges, data driven on falling edges.
// R25 - Erase and program ignored while write enable latch is clear.
// R26 - Opcodes 66h and 99h are reset arm and reset.
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_seq #(
   parameter int BLOCK_ERASE_CYC  = sfcmd_pkg::BLOCK_ERASE_CYC,
   parameter int CHIP_ERASE_CYC   = sfcmd_pkg::CHIP_ERASE_CYC,
   parameter int PAGE_PROGRAM_CYC = sfcmd_pkg::PAGE_PROGRAM_CYC
) (
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_sclk,
   input  wire logic       spi_si,
   input  wire logic [2:0] upper_io_lines,
   input  wire logic [4:0] block_protect_bits,
   output logic            spi_so,
   output logic            spi_so_oe,
   output logic            write_in_progress,
   output logic            write_enable_latch,
   output logic            deep_power_down,
   output logic            array_op_start,
   output logic [1:0]      array_op_kind,
   output logic [23:0]     array_op_addr
);
   typedef enum logic [2:0] {SFC_OPC, SFC_ADDR, SFC_DATA, SFC_TXID, SFC_SKIP} sfc_phase_e;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers and serial clock edges

   logic [2:0] pins_s;
   logic       cs_n_s;
   logic       cs_act_s;
   logic       sclk_s;
   logic       si_s;
   logic       sclk_d_reg;
   logic       cs_d_reg;
   logic       rise;
   logic       fall;
   logic       cs_rise;

   sfc_sync #(.W(3)) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .din    ({!spi_cs_n, spi_sclk, spi_si}),
      .dout   (pins_s)
   );
   // Select synchronised active high so reset reads as deselected
   assign {cs_act_s, sclk_s, si_s} = pins_s;
   assign cs_n_s = !cs_act_s;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         sclk_d_reg <= 1'b0;
         cs_d_reg   <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_d_reg   <= cs_n_s;
      end
   end

   assign rise    = !cs_n_s && sclk_s && !sclk_d_reg; // R24
   assign fall    = !cs_n_s && !sclk_s && sclk_d_reg; // R24
   assign cs_rise = cs_n_s && !cs_d_reg;

   function automatic logic is_write_op(input logic [7:0] op);
      is_write_op = (op == sfcmd_pkg::OP_BLOCK_ERASE_64K) || (op == sfcmd_pkg::OP_PAGE_PROGRAM)
                    || (op == sfcmd_pkg::OP_CHIP_ERASE) || (op == sfcmd_pkg::OP_CHIP_ERASE_ALT);
   endfunction

   // Protected region check: low four BP bits count protected top 64K blocks in every 16-block group, BP bit 4 protects all
   function automatic logic is_protected(input logic [4:0] bp, input logic [23:0] a);
      logic [7:0] blk;
      blk = a[23:16];
      if (bp == sfcmd_pkg::BP_NONE)
         is_protected = 1'b0;
      else if (bp[4])
         is_protected = 1'b1;
      else
         is_protected = ({4'h0, 4'hF - blk[3:0]} < {4'h0, bp[3:0]});
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Serial shifter

   sfc_array_if aif ();

   sfc_phase_e  phase_reg;
   logic [7:0]  opc_reg;
   logic [7:0]  sh_reg;
   logic [2:0]  bit_reg;
   logic [1:0]  abyte_reg;
   logic [23:0] addr_reg;
   logic [8:0]  dcnt_reg;
   logic [7:0]  pidx_reg;
   logic        byte_done;
   logic [7:0]  byte_val;
   logic [1:0]  id_sel_reg;
   logic [7:0]  tx_reg;
   logic [2:0]  tx_bit_reg;
   logic        pd_busy;

   assign byte_done = rise && (bit_reg == 3'd7);
   assign byte_val  = {sh_reg[6:0], si_s};
   assign pd_busy   = write_in_progress;

   always_ff @(posedge mclk) begin
      if (!resetn || cs_n_s) begin
         phase_reg <= SFC_OPC;
         bit_reg   <= '0;
         abyte_reg <= '0;
         dcnt_reg  <= '0;
         sh_reg    <= '0;
         opc_reg   <= '0;
         addr_reg  <= '0;
      end else if (rise) begin
         sh_reg  <= byte_val;
         bit_reg <= bit_reg + 3'd1;
         if (byte_done) begin
            case (phase_reg)
               SFC_OPC: begin
                  opc_reg <= byte_val;
                  if (deep_power_down && byte_val != sfcmd_pkg::OP_WAKE_SIGNATURE)
                     phase_reg <= SFC_SKIP; // R15
                  else if (pd_busy && (byte_val == sfcmd_pkg::OP_JEDEC_ID
                           || byte_val == sfcmd_pkg::OP_WAKE_SIGNATURE))
                     phase_reg <= SFC_SKIP; // R18 R20
                  else if (byte_val == sfcmd_pkg::OP_BLOCK_ERASE_64K
                           || byte_val == sfcmd_pkg::OP_PAGE_PROGRAM
                           || byte_val == sfcmd_pkg::OP_MAKER_DEVICE_ID
                           || byte_val == sfcmd_pkg::OP_WAKE_SIGNATURE)
                     phase_reg <= SFC_ADDR;
                  else if (byte_val == sfcmd_pkg::OP_JEDEC_ID)
                     phase_reg <= SFC_TXID;
                  else
                     phase_reg <= SFC_SKIP;
               end
               SFC_ADDR: begin
                  addr_reg  <= {addr_reg[15:0], byte_val};
                  abyte_reg <= abyte_reg + 2'd1;
                  if (abyte_reg == 2'd2)
                     phase_reg <= (opc_reg == sfcmd_pkg::OP_PAGE_PROGRAM) ? SFC_DATA
                                : (opc_reg == sfcmd_pkg::OP_BLOCK_ERASE_64K) ? SFC_SKIP
                                : SFC_TXID; // R19 R17
               end
               SFC_DATA: begin
                  if (dcnt_reg != 9'h100)
                     dcnt_reg <= dcnt_reg + 9'd1; // R11
               end
               default: phase_reg <= phase_reg;
            endcase
         end
      end
   end

   // Page load with in-page wrap; later bytes overwrite earlier ones
   always_ff @(posedge mclk) begin
      aif.load_we   <= 1'b0;
      aif.load_data <= byte_val;
      aif.load_idx  <= pidx_reg;
      if (!resetn) begin
         pidx_reg <= '0;
      end else if (byte_done && phase_reg == SFC_ADDR && abyte_reg == 2'd2) begin
         pidx_reg <= byte_val; // R10
      end else if (byte_done && phase_reg == SFC_DATA && !pd_busy) begin
         aif.load_we <= 1'b1;
         pidx_reg    <= pidx_reg + 8'd1; // R10 R11
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ID output, driven on falling edges

   logic [7:0] id_byte;

   always_comb begin
      case (opc_reg)
         sfcmd_pkg::OP_JEDEC_ID: id_byte = (id_sel_reg == 2'd0) ? sfcmd_pkg::ID_MAKER
            : (id_sel_reg == 2'd1) ? sfcmd_pkg::ID_MEM_TYPE : sfcmd_pkg::ID_MEM_DENSITY; // R20
         sfcmd_pkg::OP_MAKER_DEVICE_ID: id_byte = id_sel_reg[0] ? sfcmd_pkg::ID_DEVICE
            : sfcmd_pkg::ID_MAKER; // R19
         default: id_byte = sfcmd_pkg::ID_SIGNATURE; // R17
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn || cs_n_s) begin
         spi_so     <= 1'b0;
         spi_so_oe  <= 1'b0;
         tx_bit_reg <= '0;
         id_sel_reg <= '0;
         tx_reg     <= '0;
      end else if (phase_reg == SFC_TXID && fall) begin // R24
         spi_so_oe  <= 1'b1;
         tx_bit_reg <= tx_bit_reg + 3'd1;
         if (tx_bit_reg == 3'd0) begin
            tx_reg <= id_byte;
            spi_so <= id_byte[7]; // R19 R20
         end else begin
            spi_so <= tx_reg[3'd7 - tx_bit_reg]; // R19 R20
         end
         if (tx_bit_reg == 3'd7)
            id_sel_reg <= (opc_reg == sfcmd_pkg::OP_MAKER_DEVICE_ID) ? {1'b0, ~id_sel_reg[0]}
                        : (id_sel_reg == 2'd2) ? 2'd2 : id_sel_reg + 2'd1; // R20
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command completion at chip select rise

   logic        reset_armed_reg;
   logic        soft_reset;
   logic        boundary;
   logic [31:0] pd_cnt_reg;
   logic        pd_entry_reg;
   logic        pd_exit_reg;

   assign boundary   = (bit_reg == 3'd0);
   assign soft_reset = cs_rise && boundary && phase_reg == SFC_SKIP
                       && opc_reg == sfcmd_pkg::OP_RESET && reset_armed_reg
                       && !deep_power_down; // R15 R22 R26

   always_ff @(posedge mclk) begin
      if (!resetn || soft_reset) begin
         reset_armed_reg <= 1'b0;
      end else if (cs_rise && boundary && phase_reg != SFC_OPC) begin
         reset_armed_reg <= (opc_reg == sfcmd_pkg::OP_RESET_ARM); // R21 R22 R26
      end
   end

   always_ff @(posedge mclk) begin
      aif.start <= 1'b0;
      if (!resetn || soft_reset) begin
         write_enable_latch <= 1'b0; // R22
         aif.op             <= sfcmd_pkg::SFC_ARR_NONE;
         aif.addr           <= '0;
      end else if (write_in_progress && !aif.busy) begin
         write_enable_latch <= 1'b0; // R5
      end else if (cs_rise && boundary && !write_in_progress && !deep_power_down) begin
         if (opc_reg == sfcmd_pkg::OP_WRITE_ENABLE && phase_reg == SFC_SKIP)
            write_enable_latch <= 1'b1;
         else if (opc_reg == sfcmd_pkg::OP_WRITE_DISABLE && phase_reg == SFC_SKIP)
            write_enable_latch <= 1'b0;
         else if (write_enable_latch) begin // R25
            if (opc_reg == sfcmd_pkg::OP_BLOCK_ERASE_64K && phase_reg == SFC_SKIP) begin // R4
               aif.start <= !is_protected(block_protect_bits, addr_reg); // R6
               aif.op    <= sfcmd_pkg::SFC_ARR_ERASE_BLOCK; // R1 R2
               aif.addr  <= {addr_reg[23:16], 16'h0000}; // R1
            end else if ((opc_reg == sfcmd_pkg::OP_CHIP_ERASE
                          || opc_reg == sfcmd_pkg::OP_CHIP_ERASE_ALT) && phase_reg == SFC_SKIP) begin
               aif.start <= (block_protect_bits == sfcmd_pkg::BP_NONE); // R7 R8
               aif.op    <= sfcmd_pkg::SFC_ARR_ERASE_CHIP;
               aif.addr  <= '0;
            end else if (phase_reg == SFC_DATA && dcnt_reg != 9'h000) begin // R9
               aif.start <= !is_protected(block_protect_bits, addr_reg); // R6
               aif.op    <= sfcmd_pkg::SFC_ARR_PROGRAM;
               aif.addr  <= {addr_reg[23:8], 8'h00};
            end
            if (is_write_op(opc_reg) && is_protected(block_protect_bits, addr_reg))
               write_enable_latch <= 1'b0;
         end
      end
   end

   // Busy flag set on start, cleared one cycle after the array timer goes idle
   always_ff @(posedge mclk) begin
      if (!resetn || soft_reset)
         write_in_progress <= 1'b0; // R23
      else if (aif.start)
         write_in_progress <= 1'b1; // R5
      else if (write_in_progress && !aif.busy)
         write_in_progress <= 1'b0; // R5
   end

   assign aif.abort = soft_reset; // R23

   ////////////////////////////////////////////////////////////////////////
   // Deep power-down entry and exit delays

   always_ff @(posedge mclk) begin
      if (!resetn || soft_reset) begin
         deep_power_down <= 1'b0;
         pd_entry_reg    <= 1'b0;
         pd_exit_reg     <= 1'b0;
         pd_cnt_reg      <= '0;
      end else if (pd_entry_reg || pd_exit_reg) begin
         if (pd_cnt_reg <= 32'h0000_0001) begin
            deep_power_down <= pd_entry_reg; // R14 R16
            pd_entry_reg    <= 1'b0;
            pd_exit_reg     <= 1'b0;
         end
         pd_cnt_reg <= pd_cnt_reg - 32'h0000_0001;
      end else if (cs_rise && boundary && !write_in_progress) begin
         if (!deep_power_down && opc_reg == sfcmd_pkg::OP_DEEP_POWER_DOWN
             && phase_reg == SFC_SKIP) begin // R13
            pd_entry_reg <= 1'b1;
            pd_cnt_reg   <= 32'(sfcmd_pkg::PD_ENTRY_CYC); // R14
         end else if (deep_power_down && opc_reg == sfcmd_pkg::OP_WAKE_SIGNATURE
                      && phase_reg != SFC_OPC) begin // R15 R16 R17
            pd_exit_reg <= 1'b1;
            pd_cnt_reg  <= 32'(sfcmd_pkg::PD_EXIT_CYC); // R16
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Array timer and observable outputs

   sfc_array_timer #(
      .BLOCK_ERASE_CYC  (BLOCK_ERASE_CYC),
      .CHIP_ERASE_CYC   (CHIP_ERASE_CYC),
      .PAGE_PROGRAM_CYC (PAGE_PROGRAM_CYC)
   ) u_timer (
      .mclk   (mclk),
      .resetn (resetn),
      .arr    (aif.arr)
   );

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         array_op_start <= 1'b0;
         array_op_kind  <= '0;
         array_op_addr  <= '0;
      end else begin
         array_op_start <= aif.start;
         array_op_kind  <= aif.op;
         array_op_addr  <= aif.addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_cs_end;
      cs_rise && boundary;
   endsequence

   a_wip_follows_start: assert property (@(posedge mclk) disable iff (!resetn)
      aif.start |=> write_in_progress) // R5
      else $error("busy flag not set after start");
   a_wel_needed: assert property (@(posedge mclk) disable iff (!resetn)
      aif.start |-> $past(write_enable_latch)) // R25
      else $error("array cycle without write enable");
   a_chip_protect: assert property (@(posedge mclk) disable iff (!resetn)
      aif.start && aif.op == sfcmd_pkg::SFC_ARR_ERASE_CHIP |-> block_protect_bits == 5'h00) // R8
      else $error("chip erase while protected");
   a_start_on_end: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(aif.start) |-> $past(cs_rise && boundary)) // R4
      else $error("array start without byte-aligned deselect");
   a_reset_abort: assert property (@(posedge mclk) disable iff (!resetn)
      soft_reset |=> !write_in_progress && !write_enable_latch) // R23
      else $error("reset did not abort cycle");
   a_pd_entry_wait: assert property (@(posedge mclk) disable iff (!resetn)
      s_cs_end ##1 pd_entry_reg |-> !deep_power_down [*2]) // R14
      else $error("power-down entered early");
   a_so_on_fall: assert property (@(posedge mclk) disable iff (!resetn)
      $changed(spi_so) && !$past(cs_n_s) |-> $past(fall)) // R24
      else $error("output changed off falling edge");
   a_wip_clears_wel: assert property (@(posedge mclk) disable iff (!resetn)
      $fell(write_in_progress) |-> !write_enable_latch) // R5
      else $error("latch still set after cycle");
endmodule
`default_nettype wire

// ---- inc/sfcmd_pkg.sv ----
package sfcmd_pkg;
   localparam logic [7:0] OP_BLOCK_ERASE_64K  = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE       = 8'hC7;
   localparam logic [7:0] OP_CHIP_ERASE_ALT   = 8'h60;
   localparam logic [7:0] OP_PAGE_PROGRAM     = 8'h02;
   localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
   localparam logic [7:0] OP_DEEP_POWER_DOWN  = 8'hB9;
   localparam logic [7:0] OP_WAKE_SIGNATURE   = 8'hAB;
   localparam logic [7:0] OP_MAKER_DEVICE_ID  = 8'h90;
   localparam logic [7:0] OP_JEDEC_ID         = 8'h9F;
   localparam logic [7:0] OP_NO_OPERATION     = 8'h00;
   localparam logic [7:0] OP_RESET_ARM        = 8'h66;
   localparam logic [7:0] OP_RESET            = 8'h99;

   // Arbitrary identity values
   localparam logic [7:0] ID_MAKER            = 8'h5A;
   localparam logic [7:0] ID_MEM_TYPE         = 8'h3C;
   localparam logic [7:0] ID_MEM_DENSITY      = 8'h21;
   localparam logic [7:0] ID_DEVICE           = 8'h17;
   localparam logic [7:0] ID_SIGNATURE        = 8'h17;

   localparam int ADDR_W        = 24;
   localparam int PAGE_BYTES    = 256;
   localparam int BP_W          = 5;
   localparam logic [4:0] BP_NONE = 5'h00;

   localparam int CLK_HZ                    = 25_000_000;
   localparam int BLOCK_ERASE_TIME_US       = 1000;
   localparam int CHIP_ERASE_TIME_US        = 2000;
   localparam int PAGE_PROGRAM_TIME_US      = 100;
   localparam int POWER_DOWN_ENTRY_DELAY_US = 3;
   localparam int POWER_DOWN_EXIT_DELAY_US  = 8;
   localparam int BLOCK_ERASE_CYC  = BLOCK_ERASE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int CHIP_ERASE_CYC   = CHIP_ERASE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * (CLK_HZ / 1_000_000);
   localparam int PD_ENTRY_CYC     = POWER_DOWN_ENTRY_DELAY_US * (CLK_HZ / 1_000_000);
   localparam int PD_EXIT_CYC      = POWER_DOWN_EXIT_DELAY_US * (CLK_HZ / 1_000_000);

   typedef enum logic [1:0] {SFC_ARR_NONE, SFC_ARR_ERASE_BLOCK, SFC_ARR_ERASE_CHIP,
                             SFC_ARR_PROGRAM} sfc_arr_op_e;
endpackage

// ---- inc/sfc_array_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sfc_array_if;
   logic                  start;
   sfcmd_pkg::sfc_arr_op_e op;
   logic [23:0]           addr;
   logic                  abort;
   logic                  load_we;
   logic [7:0]            load_idx;
   logic [7:0]            load_data;
   logic                  busy;
   modport seq (output start, output op, output addr, output abort,
                output load_we, output load_idx, output load_data, input busy);
   modport arr (input start, input op, input addr, input abort,
                input load_we, input load_idx, input load_data, output busy);
endinterface
`default_nettype wire

// ---- hw/sfc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfc_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         meta_reg <= '0;
         dout     <= '0;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ---- hw/sfc_array_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfc_array_timer #(
   parameter int BLOCK_ERASE_CYC  = sfcmd_pkg::BLOCK_ERASE_CYC,
   parameter int CHIP_ERASE_CYC   = sfcmd_pkg::CHIP_ERASE_CYC,
   parameter int PAGE_PROGRAM_CYC = sfcmd_pkg::PAGE_PROGRAM_CYC
) (
   input  wire logic mclk,
   input  wire logic resetn,
   sfc_array_if.arr  arr
);
   // Page buffer written on load strobes; the timer only counts cycles and never reads it
   logic [7:0]  page_buf [0:255];
   logic [31:0] cnt_reg;

   always_ff @(posedge mclk) begin
      if (arr.load_we)
         page_buf[arr.load_idx] <= arr.load_data;
   end

   always_ff @(posedge mclk) begin
      if (!resetn || arr.abort) begin
         arr.busy <= 1'b0;
         cnt_reg  <= '0;
      end else if (arr.start && !arr.busy) begin
         arr.busy <= 1'b1;
         case (arr.op)
            sfcmd_pkg::SFC_ARR_ERASE_BLOCK: cnt_reg <= 32'(BLOCK_ERASE_CYC);
            sfcmd_pkg::SFC_ARR_ERASE_CHIP:  cnt_reg <= 32'(CHIP_ERASE_CYC);
            default:                        cnt_reg <= 32'(PAGE_PROGRAM_CYC);
         endcase
      end else if (arr.busy) begin
         if (cnt_reg <= 32'h0000_0001)
            arr.busy <= 1'b0;
         cnt_reg <= cnt_reg - 32'h0000_0001;
      end
   end
endmodule
`default_nettype wire

// ---- bench/sfc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
   output logic      spi_cs_n,
   output logic      spi_sclk,
   output logic      spi_si,
   input  wire logic spi_so
);
   logic [7:0] rx_byte;
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_si   = 1'b0;
   end
   // Shift nb bits MSB first, 320 ns link clock
   task automatic xfer(input logic [7:0] tx, input int nb);
      for (int i = 7; i > 7 - nb; i--) begin
         spi_si = tx[i];
         #160 rx_byte = {rx_byte[6:0], spi_so};
         spi_sclk = 1'b1;
         #160 spi_sclk = 1'b0;
      end
   endtask
   task automatic sel();
      #320 spi_cs_n = 1'b0;
      #160;
   endtask
   // Released data line shows inverse of last bit
   task automatic desel();
      #160 spi_cs_n = 1'b1;
      spi_si = ~spi_si;
   endtask
endmodule
`default_nettype wire

// ---- bench/sfc_flash_seq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_seq_tb;
   logic        mclk;
   logic        resetn;
   logic        spi_cs_n;
   logic        spi_sclk;
   logic        spi_si;
   logic [2:0]  upper_io_lines;
   logic [4:0]  block_protect_bits;
   logic        spi_so;
   logic        spi_so_oe;
   logic        write_in_progress;
   logic        write_enable_latch;
   logic        deep_power_down;
   logic        array_op_start;
   logic [1:0]  array_op_kind;
   logic [23:0] array_op_addr;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          c;
   logic [7:0]  rnd = 8'h2E;
   logic [23:0] ad;
   sfc_flash_seq #(.BLOCK_ERASE_CYC(50), .CHIP_ERASE_CYC(600), .PAGE_PROGRAM_CYC(50))
      u_sfc_flash_seq (.mclk(mclk), .resetn(resetn), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_si(spi_si), .upper_io_lines(upper_io_lines),
      .block_protect_bits(block_protect_bits), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
      .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
      .deep_power_down(deep_power_down), .array_op_start(array_op_start),
      .array_op_kind(array_op_kind), .array_op_addr(array_op_addr));
   sfc_host u_sfc_host (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_si(spi_si),
      .spi_so(spi_so));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wt(ref logic s, input logic lv, input int lim, output int n);
      n = 0;
      while (s !== lv && n < lim) begin
         @(posedge mclk) #1;
         n++;
      end
   endtask
   // Frame of n whole bytes plus xb stray bits
   task automatic send(input logic [39:0] v, input int n, input int xb);
      @(posedge mclk) #1 upper_io_lines = rnd[2:0];
      rnd = lfsr(rnd);
      u_sfc_host.sel();
      for (int i = 0; i < n; i++) u_sfc_host.xfer(v[39-8*i -: 8], 8);
      if (xb > 0) u_sfc_host.xfer(8'hA5, xb);
      u_sfc_host.desel();
   endtask
   task automatic op1(input logic [7:0] o);
      send({o, 32'h0000_0000}, 1, 0);
   endtask
   task automatic op(input logic we, input logic [39:0] v, input int n, input int xb,
                     input logic [4:0] bp, input logic [1:0] k, input logic [23:0] a);
      int m;
      if (we) op1(sfcmd_pkg::OP_WRITE_ENABLE);
      wt(write_enable_latch, we, 20, m);
      chk(write_enable_latch, we);
      @(posedge mclk) #1 block_protect_bits = bp;
      send(v, n, xb);
      wt(array_op_start, 1'b1, 40, m);
      chk(m < 40, k != 2'h0);
      if (k != 2'h0) begin
         chk(array_op_kind, k);
         chk(array_op_addr, a);
         chk(write_in_progress, 1'b1);
         wt(write_in_progress, 1'b0, 700, m);
         chk(m inside {[46:54]} || (k == 2'h2 && m inside {[596:604]}), 1'b1);
         chk(write_enable_latch, 1'b0);
      end
   endtask
   task automatic rd(input logic [7:0] o, input int nd, input logic [23:0] e);
      logic [23:0] g;
      @(posedge mclk) #1;
      u_sfc_host.sel();
      u_sfc_host.xfer(o, 8);
      repeat (nd) u_sfc_host.xfer(8'h00, 8);
      for (int i = 0; i < 3; i++) begin
         u_sfc_host.xfer(8'h00, 8);
         g = {g[15:0], u_sfc_host.rx_byte};
      end
      chk(spi_so_oe, 1'b1);
      u_sfc_host.desel();
      chk(g, e);
   endtask
   task automatic summarize();
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #3_000_000;
      num_errors++;
      summarize();
   end
   initial begin
      resetn = 1'b0;
      upper_io_lines = 3'h0;
      block_protect_bits = 5'h00;
      repeat (5) @(posedge mclk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge mclk);
      chk({write_in_progress, write_enable_latch, deep_power_down, spi_so_oe}, 4'h0);
      ad = {rnd, lfsr(rnd), 8'h5C};
      rnd = lfsr(lfsr(rnd));
      op(0, {8'hD8, ad, 8'h00}, 4, 0, 5'h00, 2'h0, 24'h00_0000);
      op(1, {8'hD8, ad, 8'h00}, 4, 0, 5'h00, 2'h1, {ad[23:16], 16'h0000});
      op(1, {8'hD8, ad, 8'h00}, 4, 3, 5'h00, 2'h0, 24'h00_0000);
      op(1, {8'hD8, ad, 8'h00}, 4, 0, 5'h10, 2'h0, 24'h00_0000);
      op(1, {8'hC7, 32'h0000_0000}, 1, 0, 5'h01, 2'h0, 24'h00_0000);
      op(1, {8'hC7, 32'h0000_0000}, 1, 0, 5'h00, 2'h2, 24'h00_0000);
      op(1, {8'h60, 32'h0000_0000}, 1, 0, 5'h00, 2'h2, 24'h00_0000);
      op(1, {8'h02, ad, rnd}, 5, 0, 5'h00, 2'h3, {ad[23:8], 8'h00});
      op(1, {8'h02, ad, rnd}, 5, 3, 5'h00, 2'h0, 24'h00_0000);
      // Aligned whole page plus one byte more
      op1(sfcmd_pkg::OP_WRITE_ENABLE);
      @(posedge mclk) #1;
      u_sfc_host.sel();
      u_sfc_host.xfer(sfcmd_pkg::OP_PAGE_PROGRAM, 8);
      for (int i = 0; i < 260; i++)
         u_sfc_host.xfer((i == 2) ? 8'h00 : (i < 2) ? ad[23-8*i -: 8] : rnd, 8);
      u_sfc_host.desel();
      wt(array_op_start, 1'b1, 40, c);
      chk(c < 40, 1'b1);
      chk(array_op_kind, 2'h3);
      chk(array_op_addr, {ad[23:8], 8'h00});
      wt(write_in_progress, 1'b0, 700, c);
      chk(write_enable_latch, 1'b0);
      $display("test erase_program done");
      rd(sfcmd_pkg::OP_JEDEC_ID, 0, {sfcmd_pkg::ID_MAKER, sfcmd_pkg::ID_MEM_TYPE,
         sfcmd_pkg::ID_MEM_DENSITY});
      rd(sfcmd_pkg::OP_MAKER_DEVICE_ID, 3, {sfcmd_pkg::ID_MAKER, sfcmd_pkg::ID_DEVICE,
         sfcmd_pkg::ID_MAKER});
      $display("test id_read done");
      op1(sfcmd_pkg::OP_DEEP_POWER_DOWN);
      wt(deep_power_down, 1'b1, 200, c);
      chk(c inside {[sfcmd_pkg::PD_ENTRY_CYC-2:sfcmd_pkg::PD_ENTRY_CYC+8]}, 1'b1);
      op1(sfcmd_pkg::OP_WRITE_ENABLE);
      wt(write_enable_latch, 1'b1, 20, c);
      chk(write_enable_latch, 1'b0);
      send({sfcmd_pkg::OP_WAKE_SIGNATURE, 32'h0000_0000}, 1, 1);
      wt(deep_power_down, 1'b0, 300, c);
      chk(deep_power_down, 1'b1);
      op1(sfcmd_pkg::OP_WAKE_SIGNATURE);
      wt(deep_power_down, 1'b0, 400, c);
      chk(c inside {[sfcmd_pkg::PD_EXIT_CYC-2:sfcmd_pkg::PD_EXIT_CYC+8]}, 1'b1);
      $display("test power_down done");
      op1(sfcmd_pkg::OP_WRITE_ENABLE);
      op1(sfcmd_pkg::OP_CHIP_ERASE);
      wt(write_in_progress, 1'b1, 40, c);
      op1(sfcmd_pkg::OP_RESET_ARM);
      op1(sfcmd_pkg::OP_NO_OPERATION);
      op1(sfcmd_pkg::OP_RESET);
      chk(write_in_progress, 1'b1);
      op1(sfcmd_pkg::OP_RESET_ARM);
      op1(sfcmd_pkg::OP_RESET);
      wt(write_in_progress, 1'b0, 40, c);
      chk({write_in_progress, write_enable_latch}, 2'h0);
      $display("test soft_reset done");
      summarize();
   end
endmodule
`default_nettype wire
